// [core/pgi_power_good.sv]
// power-good indicator logic with its two control registers
`timescale 1ns/100ps
module pgi_power_good #(
    parameter logic [6:0] DEV_ADDR = pgi_pkg::PGI_DEV_ADDR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe_n,
    input wire pgi_pkg::pgi_stat_t stat_in,
    input wire logic [7:0] vos_pct,
    input wire logic ss_near,
    input wire logic first_gate,
    output logic power_good_out,
    output logic power_good_oe_n,
    output logic ss_pull_low,
    output logic ctrl_sw_off
);

    // ==========================================================
    // register port
    // ==========================================================
    pgi_pkg::pgi_wr_t wr;     // write strobe from the serial port
    logic [7:0] ptr;          // register pointer
    logic [7:0] rdata;        // read data for the pointer
    logic good_mode_field_q;  // mode bit
    logic [1:0] good_level_select_q; // level field

    pgi_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .wr(wr),
        .ptr(ptr),
        .rdata(rdata)
    );

    // field writes; other bits of each byte are not stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            good_mode_field_q <= pgi_pkg::PGI_MODE_RST;
            good_level_select_q <= pgi_pkg::PGI_LEVEL_RST;
        end else if (wr.stb) begin
            if (wr.addr == pgi_pkg::PGI_MODE_OFS) begin
                good_mode_field_q <= wr.data[pgi_pkg::PGI_MODE_POS];
            end
            if (wr.addr == pgi_pkg::PGI_LEVEL_OFS) begin
                good_level_select_q <=
                    wr.data[pgi_pkg::PGI_LEVEL_POS +: 2];
            end
        end
    end

    // read mux: reserved bits and unmapped offsets read zero
    always_comb begin
        rdata = 8'h00;
        if (ptr == pgi_pkg::PGI_MODE_OFS) begin
            rdata[pgi_pkg::PGI_MODE_POS] = good_mode_field_q;
        end else if (ptr == pgi_pkg::PGI_LEVEL_OFS) begin
            rdata[pgi_pkg::PGI_LEVEL_POS +: 2] = good_level_select_q;
        end
    end

    // ==========================================================
    // input synchronisers
    // ==========================================================
    pgi_pkg::pgi_stat_t st_s1_q, st_s2_q, st_s3_q; // status chain
    pgi_pkg::pgi_stat_t st_q;                      // accepted status
    logic [7:0] vos_s1_q, vos_s2_q, vos_s3_q;      // sense word chain
    logic [7:0] vos_q;                             // accepted sense word

    // status bits: a bit changes once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
            st_s3_q <= '0;
            st_q <= '0;
        end else begin
            st_s1_q <= stat_in;
            st_s2_q <= st_s1_q;
            st_s3_q <= st_s2_q;
            st_q <= (st_s2_q & st_s3_q) | (st_q & (st_s2_q | st_s3_q));
        end
    end

    // sense word: taken whole only when two stages match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vos_s1_q <= 8'h00;
            vos_s2_q <= 8'h00;
            vos_s3_q <= 8'h00;
            vos_q <= 8'h00;
        end else begin
            vos_s1_q <= vos_pct;
            vos_s2_q <= vos_s1_q;
            vos_s3_q <= vos_s2_q;
            if (vos_s2_q == vos_s3_q) begin
                vos_q <= vos_s3_q;
            end
        end
    end

    // ==========================================================
    // thresholds and qualification
    // ==========================================================
    logic [7:0] upper_pct;  // selected upper threshold
    logic [7:0] lower_pct;  // upper less hysteresis
    logic above, below;     // comparison results
    logic qual;             // enable, supply and no fault
    logic start_q;          // start-up not yet complete
    logic gate_seen_q;      // first control gate pulse seen
    logic ovp_latch_q;      // over-voltage latch
    logic good_d;           // next good value

    // upper = 80 + 5 * code, built as base + 4*code + code
    assign upper_pct = pgi_pkg::PGI_BASE_PCT
                     + {4'h0, good_level_select_q, 2'h0}
                     + {6'h00, good_level_select_q};
    assign lower_pct = upper_pct - pgi_pkg::PGI_HYST_PCT;
    assign above = vos_q > upper_pct;
    assign below = vos_q < lower_pct;
    assign qual = st_q.en_ok & st_q.vcc_ok & ~st_q.ocp & ~st_q.ovp
                & ~st_q.otp & ~ovp_latch_q;

    // over-voltage latch: cleared only by taking enable away
    // set wins over the clear when both fall in one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovp_latch_q <= 1'b0;
        end else if (st_q.ovp) begin
            ovp_latch_q <= 1'b1;
        end else if (!st_q.en_ok) begin
            ovp_latch_q <= 1'b0;
        end
    end

    // control switch off and soft-start pull-down outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_sw_off <= 1'b0;
            ss_pull_low <= 1'b0;
        end else begin
            ctrl_sw_off <= st_q.ovp | ovp_latch_q;
            ss_pull_low <= st_q.ocp;
        end
    end

    // gate tracker: rearmed whenever qualification is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_seen_q <= 1'b0;
        end else if (!qual) begin
            gate_seen_q <= 1'b0;
        end else if (first_gate) begin
            gate_seen_q <= 1'b1;
        end
    end

    // start-up phase: ends on first assertion of good
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b1;
        end else if (!qual) begin
            start_q <= 1'b1;
        end else if (good_d) begin
            start_q <= 1'b0;
        end
    end

    // ==========================================================
    // good decision
    // ==========================================================
    always_comb begin
        good_d = power_good_out;
        if (!qual) begin
            // any disqualifier drops good on the next edge
            good_d = 1'b0;
        end else if (start_q) begin
            if (!gate_seen_q) begin
                good_d = 1'b0;
            end else if (good_mode_field_q == pgi_pkg::PGI_MODE_RAMP) begin
                good_d = ss_near;
            end else begin
                good_d = above;
            end
        end else if (above) begin
            // running: same hysteresis in both modes
            good_d = 1'b1;
        end else if (below) begin
            good_d = 1'b0;
        end
    end

    // pin drive: enable low pulls the open-drain pin low
    // the pin is released only while good is high, never in between
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_good_out <= 1'b0;
            power_good_oe_n <= 1'b0;
        end else begin
            power_good_out <= good_d;
            power_good_oe_n <= good_d;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_ready;
        qual && start_q && gate_seen_q;
    endsequence

    sequence s_running;
        qual && !start_q;
    endsequence

    a_level_upper: assert property (
        good_level_select_q == 2'h2 |-> upper_pct == 8'h5A)
        else $error("upper threshold wrong for code two");

    a_hyst_lower: assert property (
        good_level_select_q == 2'h0 |-> lower_pct == 8'h4B)
        else $error("lower threshold wrong for code zero");

    a_mode_write: assert property (
        wr.stb && wr.addr == pgi_pkg::PGI_MODE_OFS
        |=> good_mode_field_q == $past(wr.data[0]))
        else $error("mode write not taken");

    a_fault_drop: assert property (
        !qual |=> !power_good_out && !power_good_oe_n)
        else $error("good not dropped on disqualifier");

    a_hyst_hold: assert property (
        s_running and (power_good_out && !below) |=> power_good_out)
        else $error("good lost inside hysteresis band");

    a_run_rise: assert property (
        s_running and above |=> power_good_out)
        else $error("good not raised above upper threshold");

    a_ramp_start: assert property (
        s_ready and (!good_mode_field_q && ss_near) |=> power_good_out)
        else $error("good not raised at ramp near target");

    a_thr_start: assert property (
        s_ready and (good_mode_field_q && !above) |=> !power_good_out)
        else $error("good raised below upper threshold");

    a_gate_block: assert property (
        start_q && !gate_seen_q |=> !power_good_out)
        else $error("good before first gate pulse");

    a_ocp_pull: assert property (
        st_q.ocp |=> ss_pull_low && !power_good_out)
        else $error("over-current did not pull soft-start and good");

    a_ovp_latch: assert property (
        ovp_latch_q && st_q.en_ok |=> ctrl_sw_off ##1 ctrl_sw_off)
        else $error("control switch released while latched");

    a_sync_delay: assert property (
        $fell(st_q.en_ok) |=> !power_good_out)
        else $error("good held after enable dropped");

    a_first_rise: assert property (
        $rose(power_good_out) && $past(start_q) |-> $past(gate_seen_q))
        else $error("good raised without full qualification");

    a_ovp_stop: assert property (
        st_q.ovp |=> ctrl_sw_off && !power_good_out)
        else $error("over-voltage did not stop switch and good");

    a_level_top: assert property (
        good_level_select_q == 2'h3 |-> upper_pct == 8'h5F
            && lower_pct == 8'h5A)
        else $error("thresholds wrong for code three");

endmodule

// [core/pgi_pkg.sv]
// shared constants and types for the power-good indicator block
package pgi_pkg;

    // ==========================================================
    // register map
    // ==========================================================
    localparam logic [7:0] PGI_MODE_OFS = 8'h14;   // good mode register
    localparam logic [7:0] PGI_LEVEL_OFS = 8'h18;  // good level register
    localparam logic PGI_MODE_RST = 1'b1;          // threshold mode at reset
    localparam logic [1:0] PGI_LEVEL_RST = 2'h2;   // 90 percent at reset
    localparam int PGI_MODE_POS = 0;               // mode field bit
    localparam int PGI_LEVEL_POS = 0;              // level field low bit

    // ==========================================================
    // mode encodings
    // ==========================================================
    localparam logic PGI_MODE_THRESH = 1'b1;       // threshold based
    localparam logic PGI_MODE_RAMP = 1'b0;         // soft-start based

    // ==========================================================
    // thresholds in percent of target output
    // ==========================================================
    localparam logic [7:0] PGI_BASE_PCT = 8'h50;   // code 0 gives 80
    localparam logic [7:0] PGI_STEP_PCT = 8'h05;   // 5 per code step
    localparam logic [7:0] PGI_HYST_PCT = 8'h05;   // fixed hysteresis

    // ==========================================================
    // serial port
    // ==========================================================
    localparam logic [3:0] PGI_BYTE_BITS = 4'h8;   // bits per byte
    localparam logic [6:0] PGI_DEV_ADDR = 7'h2A;   // arbitrary value

    // register write strobe with its address and data
    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } pgi_wr_t;

    // status levels from the analog side, all active high
    typedef struct packed {
        logic en_ok;   // enable above threshold
        logic vcc_ok;  // supply above threshold
        logic ocp;     // over-current fault
        logic ovp;     // over-voltage fault
        logic otp;     // over-temperature fault
    } pgi_stat_t;

endpackage

// [core/pgi_i2c_slave.sv]
// serial register port slave for the power-good indicator block
`timescale 1ns/100ps
module pgi_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = pgi_pkg::PGI_DEV_ADDR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe_n,
    output pgi_pkg::pgi_wr_t wr,
    output logic [7:0] ptr,
    input wire logic [7:0] rdata
);

    // ==========================================================
    // pin synchronisers: bit 1 is clock, bit 0 is data
    // ==========================================================
    typedef enum {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK,
                  ST_RDATA, ST_RACK} pgi_i2c_st_t;

    logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q; // three-stage chain
    logic [1:0] pin_f_q;                      // accepted levels
    logic [1:0] pin_p_q;                      // previous accepted
    pgi_i2c_st_t st_q, nxt_q;                 // state, state after ack
    logic [3:0] cnt_q;                        // bit counter
    logic [7:0] sh_q;                         // shift register
    logic scl_rise, scl_fall, start_c, stop_c;

    // a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
            pin_s3_q <= 2'h3;
            pin_f_q <= 2'h3;
            pin_p_q <= 2'h3;
        end else begin
            pin_s1_q <= {scl_in, sda_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
            pin_p_q <= pin_f_q;
        end
    end

    // bus events seen on the accepted levels
    assign scl_rise = pin_f_q[1] & ~pin_p_q[1];
    assign scl_fall = ~pin_f_q[1] & pin_p_q[1];
    assign start_c = pin_f_q[1] & pin_p_q[1] & pin_p_q[0] & ~pin_f_q[0];
    assign stop_c = pin_f_q[1] & pin_p_q[1] & ~pin_p_q[0] & pin_f_q[0];

    // data output is always low; only the enable moves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ==========================================================
    // byte engine: address, register pointer, data, acks
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            sda_oe_n <= 1'b1;
            ptr <= 8'h00;
            wr <= '0;
        end else begin
            wr.stb <= 1'b0;
            if (start_c) begin
                // start or repeated start: pointer is kept
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                st_q <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                unique case (st_q)
                    ST_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise) begin
                            // sample one bit, msb first
                            sh_q <= {sh_q[6:0], pin_f_q[0]};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall &&
                                     cnt_q == pgi_pkg::PGI_BYTE_BITS) begin
                            cnt_q <= 4'h0;
                            if (st_q == ST_ADDR) begin
                                if (sh_q[7:1] == DEV_ADDR) begin
                                    sda_oe_n <= 1'b0;
                                    st_q <= ST_ACK;
                                    nxt_q <= sh_q[0] ? ST_RDATA : ST_REG;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else if (st_q == ST_REG) begin
                                ptr <= sh_q;
                                sda_oe_n <= 1'b0;
                                st_q <= ST_ACK;
                                nxt_q <= ST_WDATA;
                            end else begin
                                // extra bytes rewrite the same register
                                wr.stb <= 1'b1;
                                wr.addr <= ptr;
                                wr.data <= sh_q;
                                sda_oe_n <= 1'b0;
                                st_q <= ST_ACK;
                                nxt_q <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (nxt_q == ST_RDATA) begin
                                // drive the first read bit
                                sh_q <= {rdata[6:0], 1'b0};
                                sda_oe_n <= rdata[7];
                                cnt_q <= 4'h1;
                            end else begin
                                sda_oe_n <= 1'b1;
                            end
                            st_q <= nxt_q;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (cnt_q == pgi_pkg::PGI_BYTE_BITS) begin
                                sda_oe_n <= 1'b1;
                                cnt_q <= 4'h0;
                                st_q <= ST_RACK;
                            end else begin
                                sda_oe_n <= sh_q[7];
                                sh_q <= {sh_q[6:0], 1'b0};
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        // nack ends the read, ack sends the byte again
                        if (scl_rise) begin
                            st_q <= pin_f_q[0] ? ST_IDLE : ST_ACK;
                            nxt_q <= ST_RDATA;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// [sim/pgi_host_model.sv]
// host model: serial master, pull-ups on data and good pins
`timescale 1ns/100ps
module pgi_host_model (
    input wire logic clk,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic power_good_oe_n,
    output logic scl_q,
    output logic sda_line,
    output logic good_pin
);
    // =====
    // bus master
    logic sda_q = 1'b1; // master drive, high is released
    initial scl_q = 1'b1; // bus idles high
    assign sda_line = sda_q & (sda_oe_n | sda_o); // wired low
    assign good_pin = power_good_oe_n; // pulled up unless driven
    // set both lines, then let n edges pass
    task automatic pin(input logic c, input logic d, input int n);
        scl_q <= c;
        sda_q <= d;
        repeat (n) @(posedge clk);
    endtask
    // start or repeated start
    task automatic start();
        @(posedge clk);
        pin(scl_q, 1'b1, 4);
        pin(1'b1, 1'b1, 10);
        pin(1'b1, 1'b0, 10);
        pin(1'b0, 1'b0, 4);
    endtask
    // stop condition
    task automatic stop();
        pin(1'b0, 1'b0, 4);
        pin(1'b1, 1'b0, 10);
        pin(1'b1, 1'b1, 10);
    endtask
    // nine slots msb first, line sampled late in each high phase
    task automatic xb(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            pin(1'b0, w[i], 4);
            pin(1'b1, w[i], 8);
            r[i] = sda_line;
            pin(1'b0, w[i], 4);
        end
    endtask
    // whole write or read, ok when every slave ack came
    task automatic xfer(input logic [6:0] dev, input logic [7:0] a,
        input logic [7:0] d, input logic rd, output logic [7:0] q,
        output logic ok);
        logic [8:0] r;
        start();
        xb({dev, 2'b01}, r);
        ok = !r[0];
        xb({a, 1'b1}, r);
        ok = ok & !r[0];
        if (rd) begin
            start();
            xb({dev, 2'b11}, r);
            ok = ok & !r[0];
        end
        xb({rd ? 8'hFF : d, 1'b1}, r); // read ends with a nack
        ok = ok & (rd | !r[0]);
        q = r[8:1];
        stop();
    endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the power-good indicator block
`timescale 1ns/100ps
module tb;
    // =====
    // signals and instances
    localparam logic [4:0] OK_S = 5'h18; // enable, supply up, no fault
    localparam logic [7:0] MOFS = pgi_pkg::PGI_MODE_OFS; // mode reg
    localparam logic [7:0] LOFS = pgi_pkg::PGI_LEVEL_OFS; // level reg
    localparam int LIMIT = 40000; // cycle ceiling
    logic clk = 1'b0, rst = 1'b1; // reset held at start
    logic scl, sda_line, sda_o, sda_oe_n; // serial bus
    pgi_pkg::pgi_stat_t stat = 5'h00; // status levels
    logic [7:0] vos = 8'h00; // sensed output in percent
    logic ss_near = 1'b0, first_gate = 1'b0; // ramp flag, gate
    logic power_good_out, power_good_oe_n, good_pin; // good status
    logic ss_pull_low, ctrl_sw_off; // fault reactions
    int n_errors = 0, compares = 0, cyc = 0; // counters
    pgi_power_good pgi_power_good_inst (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .stat_in(stat),
        .vos_pct(vos), .ss_near(ss_near), .first_gate(first_gate),
        .power_good_out(power_good_out),
        .power_good_oe_n(power_good_oe_n),
        .ss_pull_low(ss_pull_low), .ctrl_sw_off(ctrl_sw_off)
    );
    pgi_host_model pgi_host_model_inst (
        .clk(clk), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .power_good_oe_n(power_good_oe_n), .scl_q(scl),
        .sda_line(sda_line), .good_pin(good_pin)
    );
    always #25 clk = ~clk; // 20 MHz
    // =====
    // tasks and tests
    // good state after one sensed value, band below upper
    function automatic logic nxt(input logic g, input logic [7:0] v,
        input logic [7:0] u);
        if (v > u) return 1'b1;
        if (v < u - 8'h05) return 1'b0;
        return g;
    endfunction
    // count a compare, report a mismatch
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // drive status, optional gate pulse, settle, check good and pin
    task automatic drv(input logic [4:0] s, input logic [7:0] v,
        input logic n, input logic gt, input logic e);
        @(posedge clk);
        stat <= s;
        vos <= v;
        ss_near <= n;
        first_gate <= gt;
        @(posedge clk);
        first_gate <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("good", {6'h00, e, e}, {6'h00, power_good_out, good_pin});
    endtask
    // register access; read data compared with e
    task automatic rw(input logic [7:0] a, input logic [7:0] d,
        input logic rd, input logic [7:0] e);
        logic [7:0] q;
        logic ok;
        pgi_host_model_inst.xfer(pgi_pkg::PGI_DEV_ADDR, a, d, rd, q, ok);
        chk("ack", 8'h01, {7'h00, ok});
        if (rd) chk("read data", e, q);
    endtask
    // counts, verdict, end of run
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        logic [7:0] u;
        logic [7:0] v;
        logic g;
        logic ok;
        void'($urandom(45486));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rw(MOFS, 8'h00, 1'b1, 8'h01);
        rw(LOFS, 8'h00, 1'b1, 8'h02);
        rw(8'h15, 8'h00, 1'b1, 8'h00); // unmapped place reads zero
        pgi_host_model_inst.xfer(pgi_pkg::PGI_DEV_ADDR ^ 7'h01, LOFS,
            8'h03, 1'b0, v, ok);
        chk("foreign ack", 8'h00, {7'h00, ok});
        rw(LOFS, 8'h00, 1'b1, 8'h02);
        drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b0);
        drv(OK_S, 8'h64, 1'b0, 1'b1, 1'b1);
        // every level code: band corners, then random values
        for (int c = 0; c < 4; c++) begin
            u = 8'h50 + 8'h05 * 8'(c);
            rw(LOFS, {6'($urandom), c[1:0]}, 1'b0, 8'h00);
            rw(LOFS, 8'h00, 1'b1, {6'h00, c[1:0]});
            drv(OK_S, u + 8'h01, 1'b0, 1'b0, 1'b1);
            drv(OK_S, u - 8'h05, 1'b0, 1'b0, 1'b1);
            drv(OK_S, u - 8'h06, 1'b0, 1'b0, 1'b0);
            drv(OK_S, u, 1'b0, 1'b0, 1'b0);
            drv(OK_S, u + 8'h01, 1'b0, 1'b0, 1'b1);
            g = 1'b1;
            repeat (12) begin
                v = u - 8'h08 + 8'($urandom_range(11));
                g = nxt(g, v, u);
                drv(OK_S, v, 1'($urandom), 1'b0, g);
            end
        end
        // each lost condition drops good until a new start
        drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            drv(OK_S ^ (5'h01 << i), 8'h64, 1'b0, 1'b0, 1'b0);
            chk("ss pull", {7'h00, i == 2}, {7'h00, ss_pull_low});
            chk("sw off", {7'h00, i == 1}, {7'h00, ctrl_sw_off});
            drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b0);
            chk("sw held", {7'h00, i == 1}, {7'h00, ctrl_sw_off});
            drv(5'h00, 8'h64, 1'b0, 1'b0, 1'b0);
            drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b0);
            chk("sw free", 8'h00, {7'h00, ctrl_sw_off});
            drv(OK_S, 8'h64, 1'b0, 1'b1, 1'b1);
        end
        // soft-start mode: start-up on the ramp flag, then the band
        rw(MOFS, 8'hFE, 1'b0, 8'h00);
        rw(MOFS, 8'h00, 1'b1, 8'h00);
        drv(5'h00, 8'h64, 1'b0, 1'b0, 1'b0);
        drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b0);
        drv(OK_S, 8'h64, 1'b0, 1'b1, 1'b0);
        drv(OK_S, 8'h5C, 1'b1, 1'b0, 1'b1);
        drv(OK_S, 8'h5C, 1'b0, 1'b0, 1'b1);
        drv(OK_S, 8'h59, 1'b0, 1'b0, 1'b0);
        drv(OK_S, 8'h64, 1'b0, 1'b0, 1'b1);
        stop_test();
    end
endmodule
